// *** hw/prcg_pkg.sv ***
// package: offsets, field positions and reset values of the reset and clock gating block
package prcg_pkg;

  // register byte offsets
  localparam logic [11:0] RST2_OFFSET   = 12'h030;
  localparam logic [11:0] IOCLK_OFFSET  = 12'h034;
  localparam logic [11:0] AHBCLK_OFFSET = 12'h038;

  // second apb group reset field positions
  localparam int SECOND_CMP_RST_BIT = 22;
  localparam int FIRST_CMP_RST_BIT  = 21;
  localparam int CONVERTER_RST_BIT  = 20;
  localparam int TIMER17_RST_BIT    = 18;
  localparam int TIMER16_RST_BIT    = 17;
  localparam int TIMER14_RST_BIT    = 15;
  localparam int SERIAL1_RST_BIT    = 14;
  localparam int SPI_RST_BIT        = 12;
  localparam int ADV_TIMER_RST_BIT  = 11;
  localparam int SYSCFG_RST_BIT     = 0;

  // io port clock gate field positions
  localparam int PORT_F_BIT = 5;
  localparam int PORT_B_BIT = 1;
  localparam int PORT_A_BIT = 0;

  // ahb clock gate field positions
  localparam int CHECKSUM_BIT   = 12;
  localparam int RAM_KEEP_BIT   = 9;
  localparam int FLASH_KEEP_BIT = 8;
  localparam int DMA_BIT        = 0;

  // values after reset
  localparam logic [31:0] RST2_RESET   = 32'h0000_0000;
  localparam logic [31:0] IOCLK_RESET  = 32'h0000_0000;
  localparam logic [31:0] AHBCLK_RESET = 32'h0000_0300;

  // implemented bits, all others read zero
  localparam logic [31:0] RST2_MASK   = 32'h0076_d801;
  localparam logic [31:0] IOCLK_MASK  = 32'h0000_0023;
  localparam logic [31:0] AHBCLK_MASK = 32'h0000_1301;

endpackage

// *** hw/prcg_regbus_if.sv ***
// interface: register access path between bus slave and register file
`timescale 1ns/1ps
interface prcg_regbus_if #(parameter int ADDR_W = 12);
  logic [ADDR_W-1:0] addr;
  logic              wrEn;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic [31:0]       rdata;
  logic              hit;

  modport apb
  (
    output addr, wrEn, wdata, wstrb,
    input  rdata, hit
  );
  modport regs
  (
    input  addr, wrEn, wdata, wstrb,
    output rdata, hit
  );
endinterface

// *** hw/prcg_apb_slave.sv ***
// module: apb slave front end, zero wait states
`timescale 1ns/1ps
module prcg_apb_slave
  import prcg_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // apb
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  // register side
  prcg_regbus_if.apb             bus
);
  typedef struct packed {
    logic [31:0] rdata;
  } prcg_apb_s;

  prcg_apb_s st_q;
  prcg_apb_s st_d;

  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;
  assign bus.wstrb = pstrb;
  // write lands at the access edge only
  assign bus.wrEn  = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~bus.hit;
  assign prdata    = st_q.rdata;

  always_comb
  begin
    st_d = st_q;
    // read data caught in setup phase
    if (psel && !penable)
    begin
      st_d.rdata = pwrite ? 32'h0000_0000 : bus.rdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule

// *** hw/prcg_mask_reg.sv ***
// module: 32-bit register with byte strobes and an implemented-bit mask
`timescale 1ns/1ps
module prcg_mask_reg
  import prcg_pkg::*;
#(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] MASK      = 32'hffff_ffff
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // write port
  input  wire logic        wrEn,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // contents
  output      logic [31:0] value,
  output      logic [31:0] nextValue
);
  typedef struct packed {
    logic [31:0] value;
  } prcg_reg_s;

  prcg_reg_s st_q;
  prcg_reg_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (wrEn)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wstrb[b])
        begin
          st_d.value[b*8 +: 8] = wdata[b*8 +: 8];
        end
      end
    end
    // reserved bits never hold a one
    st_d.value = st_d.value & MASK;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q.value <= RESET_VAL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign value     = st_q.value;
  assign nextValue = st_d.value;
endmodule

// *** hw/prcg_top.sv ***
// module: peripheral reset and clock gating registers behind apb
// How it works
// - comparator and converter bits hold reset
// - timer, serial, spi, syscfg bits hold reset
// - reset and port registers clear on reset
// - port clock gates follow bits 5,1,0
// - checksum unit clock follows bit 12
// - dma unit clock follows bit 0
// - bit 9 keeps ram clock in sleep
// - bit 8 keeps flash clock in sleep
// - run mode keeps ram and flash clocked
// - ahb gate register resets to 0x300
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module prcg_top
  import prcg_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  // power state
  input  wire logic              sleepMode,
  // peripheral reset requests
  output      logic              secondComparatorResetReq,
  output      logic              firstComparatorResetReq,
  output      logic              converterResetReq,
  output      logic              timerSeventeenResetReq,
  output      logic              timerSixteenResetReq,
  output      logic              timerFourteenResetReq,
  output      logic              firstSerialPortResetReq,
  output      logic              serialPeriphIfResetReq,
  output      logic              advancedTimerResetReq,
  output      logic              systemConfigResetReq,
  // clock enables
  output      logic              portFClockGate,
  output      logic              portBClockGate,
  output      logic              portAClockGate,
  output      logic              checksumUnitClockGate,
  output      logic              dmaUnitClockGate,
  output      logic              ramClockEn,
  output      logic              flashClockEn
);
  typedef struct packed {
    logic ramClockEn;
    logic flashClockEn;
  } prcg_top_s;

  prcg_top_s   st_q;
  prcg_top_s   st_d;
  logic [31:0] rst2Val;
  logic [31:0] ioVal;
  logic [31:0] ahbVal;
  logic [31:0] ahbNext;
  logic        selRst2;
  logic        selIo;
  logic        selAhb;

  prcg_regbus_if #(.ADDR_W(ADDR_W)) regBus ();

  prcg_apb_slave #(.ADDR_W(ADDR_W)) uApb
  (
    .mclk    (mclk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (regBus.apb)
  );

  // address decode
  assign selRst2 = (regBus.addr == RST2_OFFSET[ADDR_W-1:0]);
  assign selIo   = (regBus.addr == IOCLK_OFFSET[ADDR_W-1:0]);
  assign selAhb  = (regBus.addr == AHBCLK_OFFSET[ADDR_W-1:0]);
  assign regBus.hit = selRst2 | selIo | selAhb;

  // masked read mux, reserved bits zero
  always_comb
  begin
    regBus.rdata = 32'h0000_0000;
    if (selRst2)
    begin
      regBus.rdata = rst2Val;
    end
    else if (selIo)
    begin
      regBus.rdata = ioVal;
    end
    else if (selAhb)
    begin
      regBus.rdata = ahbVal;
    end
  end

  prcg_mask_reg #(.RESET_VAL(RST2_RESET), .MASK(RST2_MASK)) uRst2
  (
    .mclk      (mclk),
    .rst       (rst),
    .wrEn      (regBus.wrEn & selRst2),
    .wdata     (regBus.wdata),
    .wstrb     (regBus.wstrb),
    .value     (rst2Val),
    .nextValue ()
  );

  prcg_mask_reg #(.RESET_VAL(IOCLK_RESET), .MASK(IOCLK_MASK)) uIo
  (
    .mclk      (mclk),
    .rst       (rst),
    .wrEn      (regBus.wrEn & selIo),
    .wdata     (regBus.wdata),
    .wstrb     (regBus.wstrb),
    .value     (ioVal),
    .nextValue ()
  );

  prcg_mask_reg #(.RESET_VAL(AHBCLK_RESET), .MASK(AHBCLK_MASK)) uAhb
  (
    .mclk      (mclk),
    .rst       (rst),
    .wrEn      (regBus.wrEn & selAhb),
    .wdata     (regBus.wdata),
    .wstrb     (regBus.wstrb),
    .value     (ahbVal),
    .nextValue (ahbNext)
  );

  // reset requests straight from register flops
  assign secondComparatorResetReq = rst2Val[SECOND_CMP_RST_BIT];
  assign firstComparatorResetReq  = rst2Val[FIRST_CMP_RST_BIT];
  assign converterResetReq        = rst2Val[CONVERTER_RST_BIT];
  assign timerSeventeenResetReq   = rst2Val[TIMER17_RST_BIT];
  assign timerSixteenResetReq     = rst2Val[TIMER16_RST_BIT];
  assign timerFourteenResetReq    = rst2Val[TIMER14_RST_BIT];
  assign firstSerialPortResetReq  = rst2Val[SERIAL1_RST_BIT];
  assign serialPeriphIfResetReq   = rst2Val[SPI_RST_BIT];
  assign advancedTimerResetReq    = rst2Val[ADV_TIMER_RST_BIT];
  assign systemConfigResetReq     = rst2Val[SYSCFG_RST_BIT];

  // clock gates
  assign portFClockGate        = ioVal[PORT_F_BIT];
  assign portBClockGate        = ioVal[PORT_B_BIT];
  assign portAClockGate        = ioVal[PORT_A_BIT];
  assign checksumUnitClockGate = ahbVal[CHECKSUM_BIT];
  assign dmaUnitClockGate      = ahbVal[DMA_BIT];

  // memory clocks, gated only in sleep
  always_comb
  begin
    st_d = st_q;
    st_d.ramClockEn   = ~sleepMode | ahbNext[RAM_KEEP_BIT];
    st_d.flashClockEn = ~sleepMode | ahbNext[FLASH_KEEP_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q.ramClockEn   <= 1'b1;
      st_q.flashClockEn <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ramClockEn   = st_q.ramClockEn;
  assign flashClockEn = st_q.flashClockEn;

  // checks
  logic wrRst2;
  logic wrIo;
  logic wrAhb;
  logic wrMiss;

  assign wrRst2 = psel & penable & pwrite & selRst2;
  assign wrIo   = psel & penable & pwrite & selIo;
  assign wrAhb  = psel & penable & pwrite & selAhb;
  assign wrMiss = psel & penable & pwrite & ~regBus.hit;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_cmp_reset;
    (wrRst2 && pstrb[2]) |=>
      (secondComparatorResetReq == $past(pwdata[SECOND_CMP_RST_BIT])) &&
      (firstComparatorResetReq == $past(pwdata[FIRST_CMP_RST_BIT])) &&
      (converterResetReq == $past(pwdata[CONVERTER_RST_BIT]));
  endproperty
  a_cmp_reset: assert property (p_cmp_reset) else $error("comparator reset mismatch");

  property p_timer_reset;
    (wrRst2 && pstrb[1]) |=>
      (timerFourteenResetReq == $past(pwdata[TIMER14_RST_BIT])) &&
      (firstSerialPortResetReq == $past(pwdata[SERIAL1_RST_BIT])) &&
      (serialPeriphIfResetReq == $past(pwdata[SPI_RST_BIT])) &&
      (advancedTimerResetReq == $past(pwdata[ADV_TIMER_RST_BIT]));
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("timer reset mismatch");

  property p_high_timer_reset;
    (wrRst2 && pstrb[2]) |=>
      (timerSeventeenResetReq == $past(pwdata[TIMER17_RST_BIT])) &&
      (timerSixteenResetReq == $past(pwdata[TIMER16_RST_BIT]));
  endproperty
  a_high_timer_reset: assert property (p_high_timer_reset) else $error("timer pair reset");

  property p_syscfg_reset;
    (wrRst2 && pstrb[0]) |=> (systemConfigResetReq == $past(pwdata[SYSCFG_RST_BIT]));
  endproperty
  a_syscfg_reset: assert property (p_syscfg_reset) else $error("config reset mismatch");

  property p_lane_keep;
    (wrRst2 && !pstrb[2]) |=> $stable(rst2Val[23:16]);
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("unstrobed lane changed");

  property p_reset_hold;
    !wrRst2 |=> $stable(rst2Val);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset request moved unwritten");

  property p_clear_after_reset;
    @(posedge mclk) disable iff (1'b0)
      rst |=> (rst2Val == RST2_RESET) && (ioVal == IOCLK_RESET);
  endproperty
  a_clear_after_reset: assert property (p_clear_after_reset) else $error("not clear");

  property p_port_gate;
    (wrIo && pstrb[0]) |=>
      (portFClockGate == $past(pwdata[PORT_F_BIT])) &&
      (portBClockGate == $past(pwdata[PORT_B_BIT])) &&
      (portAClockGate == $past(pwdata[PORT_A_BIT]));
  endproperty
  a_port_gate: assert property (p_port_gate) else $error("port gate mismatch");

  property p_port_hold;
    !wrIo |=> $stable(ioVal);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port gate moved unwritten");

  property p_io_lane_keep;
    (wrIo && !pstrb[0]) |=> $stable(ioVal);
  endproperty
  a_io_lane_keep: assert property (p_io_lane_keep) else $error("port lane changed");

  property p_checksum_gate;
    (wrAhb && pstrb[1]) |=> (checksumUnitClockGate == $past(pwdata[CHECKSUM_BIT]));
  endproperty
  a_checksum_gate: assert property (p_checksum_gate) else $error("checksum gate");

  property p_dma_gate;
    (wrAhb && pstrb[0]) |=> (dmaUnitClockGate == $past(pwdata[DMA_BIT]));
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma gate mismatch");

  property p_ahb_hold;
    !wrAhb |=> $stable(ahbVal);
  endproperty
  a_ahb_hold: assert property (p_ahb_hold) else $error("ahb gate moved unwritten");

  property p_ahb_lane_keep;
    (wrAhb && !pstrb[1]) |=> $stable(ahbVal[15:8]);
  endproperty
  a_ahb_lane_keep: assert property (p_ahb_lane_keep) else $error("ahb lane changed");

  property p_ram_sleep;
    (sleepMode && !ahbVal[RAM_KEEP_BIT] && !wrAhb) |=> !ramClockEn;
  endproperty
  a_ram_sleep: assert property (p_ram_sleep) else $error("ram clock not gated");

  property p_ram_kept;
    (sleepMode && ahbVal[RAM_KEEP_BIT] && !wrAhb) |=> ramClockEn;
  endproperty
  a_ram_kept: assert property (p_ram_kept) else $error("ram clock not kept");

  property p_flash_sleep;
    (sleepMode && !ahbVal[FLASH_KEEP_BIT] && !wrAhb) |=> !flashClockEn;
  endproperty
  a_flash_sleep: assert property (p_flash_sleep) else $error("flash clock not gated");

  property p_flash_kept;
    (sleepMode && ahbVal[FLASH_KEEP_BIT] && !wrAhb) |=> flashClockEn;
  endproperty
  a_flash_kept: assert property (p_flash_kept) else $error("flash clock not kept");

  property p_run_clocks;
    !sleepMode |=> (ramClockEn && flashClockEn);
  endproperty
  a_run_clocks: assert property (p_run_clocks) else $error("memory clock off in run");

  property p_ahb_reset;
    @(posedge mclk) disable iff (1'b0)
      rst |=> (ahbVal == AHBCLK_RESET) && ramClockEn && flashClockEn;
  endproperty
  a_ahb_reset: assert property (p_ahb_reset) else $error("ahb reset value");

  property p_reserved_zero;
    (psel && penable && !pwrite && selRst2) |->
      ((prdata & ~RST2_MASK) == 32'h0000_0000) && (prdata == rst2Val);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_io_read;
    (psel && penable && !pwrite && selIo) |->
      ((prdata & ~IOCLK_MASK) == 32'h0000_0000) && (prdata == ioVal);
  endproperty
  a_io_read: assert property (p_io_read) else $error("port register read");

  property p_ahb_read;
    (psel && penable && !pwrite && selAhb) |->
      ((prdata & ~AHBCLK_MASK) == 32'h0000_0000) && (prdata == ahbVal);
  endproperty
  a_ahb_read: assert property (p_ahb_read) else $error("ahb register read");

  property p_miss_read;
    (psel && penable && !pwrite && !regBus.hit) |-> (prdata == 32'h0000_0000);
  endproperty
  a_miss_read: assert property (p_miss_read) else $error("unmapped read not zero");

  property p_miss_ignored;
    wrMiss |-> pslverr ##1 ($stable(rst2Val) && $stable(ioVal) && $stable(ahbVal));
  endproperty
  a_miss_ignored: assert property (p_miss_ignored) else $error("unmapped write");

  c_rst2_write: cover property (wrRst2 ##1 secondComparatorResetReq);
  c_ram_gated: cover property (sleepMode ##1 !ramClockEn);
  c_flash_kept: cover property (sleepMode ##1 flashClockEn);
  c_miss: cover property (psel && penable && pslverr);
  c_port_on: cover property (wrIo ##1 portAClockGate);
endmodule

// *** dv/prcg_tb_top.sv ***
// testbench: apb register and output checks of the reset and clock gating block
`timescale 1ns/1ps
module prcg_tb_top
  import prcg_pkg::*;
;
  localparam logic [11:0] ADS [3] = '{RST2_OFFSET, IOCLK_OFFSET, AHBCLK_OFFSET};
  localparam logic [11:0] BADS [5] = '{12'h02c, 12'h03c, 12'h000, 12'h031, 12'hfff};
  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleepMode;
  logic [16:0] outs;
  logic [31:0] shadow [3];
  logic [33:0] rdQ [$];
  logic [16:0] outQ [$];
  logic        pend = 1'b0;
  int          miscompares;
  int          nChecks;
  int          cycles;

  prcg_top prcg_top_i
  (
    .mclk                     (mclk),
    .rst                      (rst),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .sleepMode                (sleepMode),
    .secondComparatorResetReq (outs[16]),
    .firstComparatorResetReq  (outs[15]),
    .converterResetReq        (outs[14]),
    .timerSeventeenResetReq   (outs[13]),
    .timerSixteenResetReq     (outs[12]),
    .timerFourteenResetReq    (outs[11]),
    .firstSerialPortResetReq  (outs[10]),
    .serialPeriphIfResetReq   (outs[9]),
    .advancedTimerResetReq    (outs[8]),
    .systemConfigResetReq     (outs[7]),
    .portFClockGate           (outs[6]),
    .portBClockGate           (outs[5]),
    .portAClockGate           (outs[4]),
    .checksumUnitClockGate    (outs[3]),
    .dmaUnitClockGate         (outs[2]),
    .ramClockEn               (outs[1]),
    .flashClockEn             (outs[0])
  );

  function automatic logic [16:0] expOut();
    logic [31:0] a;
    logic [31:0] c;
    a = shadow[0];
    c = shadow[2];
    return {a[22], a[21], a[20], a[18], a[17], a[15], a[14], a[12], a[11], a[0],
            shadow[1][5], shadow[1][1], shadow[1][0], c[12], c[0],
            !sleepMode | c[9], !sleepMode | c[8]};
  endfunction

  function automatic int idx(logic [11:0] ad);
    return ad == ADS[0] ? 0 : ad == ADS[1] ? 1 : ad == ADS[2] ? 2 : 3;
  endfunction

  task automatic cmpRd(input logic [33:0] e);
    nChecks++;
    if ({pready, pslverr, prdata} !== e)
    begin
      miscompares++;
      $display("MISMATCH ready error read data exp %h got %h", e, {pready, pslverr, prdata});
    end
  endtask

  task automatic cmpOut(input logic [16:0] e);
    nChecks++;
    if (outs !== e)
    begin
      miscompares++;
      $display("MISMATCH outputs exp %h got %h", e, outs);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    logic [31:0] m;
    i = idx(ad);
    if (w && i < 3)
    begin
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      m = m & (i == 0 ? RST2_MASK : i == 1 ? IOCLK_MASK : AHBCLK_MASK);
      shadow[i] = (shadow[i] & ~m) | (d & m);
    end
    rdQ.push_back({1'b1, i == 3, (!w && i < 3) ? shadow[i] : 32'h0});
    outQ.push_back(expOut());
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic doReset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    shadow = '{RST2_RESET, IOCLK_RESET, AHBCLK_RESET};
  endtask

  task automatic setSleep(input logic v);
    @(posedge mclk);
    sleepMode <= v;
    repeat (2) @(posedge mclk);
  endtask

  task automatic readAll();
    for (int i = 0; i < 3; i++)
      apb(1'b0, ADS[i], 32'h0, 4'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // scoreboard: answers at the access edge, outputs one cycle later
  always @(posedge mclk)
  begin
    if (pend)
      cmpOut(outQ.pop_front());
    pend = psel && penable && pready;
    if (pend)
      cmpRd(rdQ.pop_front());
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    int i;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sleepMode = 1'b0;
    void'($urandom(32'h2ee1));
    doReset();
    readAll();
    $display("test reset values done");
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, ADS[j], 32'hffff_ffff, 4'hf);
      apb(1'b0, ADS[j], 32'h0, 4'h0);
      apb(1'b1, ADS[j], 32'h0, 4'hf);
      apb(1'b0, ADS[j], 32'h0, 4'h0);
    end
    $display("test set and clear done");
    repeat (30)
    begin
      i = $urandom_range(2, 0);
      apb(1'b1, ADS[i], $urandom, 4'($urandom));
      apb(1'b0, ADS[i], 32'h0, 4'h0);
    end
    $display("test random writes done");
    for (int s = 1; s >= 0; s--)
    begin
      setSleep(s[0]);
      for (int v = 0; v < 4; v++)
        apb(1'b1, ADS[2], (32'(v) << 8) | ($urandom & 32'h1001), 4'hf);
    end
    $display("test sleep clocks done");
    for (int j = 0; j < 5; j++)
    begin
      apb(1'b1, BADS[j], $urandom, 4'hf);
      apb(1'b0, BADS[j], 32'h0, 4'h0);
    end
    readAll();
    $display("test unmapped done");
    for (int j = 0; j < 3; j++)
      apb(1'b1, ADS[j], 32'hffff_ffff, 4'hf);
    doReset();
    readAll();
    $display("test mid-run reset done");
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule
